//--- sdct_defines.vh
// Constants for the smart DAC command and status register group
// Functional notes
// - Key field value 0101 is unlock password
// - Reset field 1010 fires full reset, self-clears
// - Bit 7 loads outputs with sync enabled
// - Bit 6 clears channels to zero/mid code
// - Bit 4 starts fault record, self-clears
// - Bit 3 launches protect, self-clears
// - Bit 2 reads one store row, self-clears
// - Bit 1 writes settings into store
// - Bit 0 restores store into register map
// - Bits 14,6,2 issue margin-low, self-clear
// - Bits 13,5,1 issue margin-high, self-clear
// - Bits 12,4,0 are waveform run levels
// - Bit 3 clears channel 1 comparator latches
// - Status packs CRC, busy, part, revision
// - Busy channel refuses margin-low/high commands
// - Busy store refuses store commands
// - User CRC flag set on load failure
`ifndef SDCT_DEFINES_VH
`define SDCT_DEFINES_VH

// Register offsets
`define SDCT_ADDR_GLOBAL   8'h20
`define SDCT_ADDR_CHANNEL  8'h21
`define SDCT_ADDR_STATUS   8'h22

// Global trigger fields
`define SDCT_KEY_HI        15
`define SDCT_KEY_LO        12
`define SDCT_RST_HI        11
`define SDCT_RST_LO        8
`define SDCT_BIT_LOAD      7
`define SDCT_BIT_CLEAR     6
`define SDCT_BIT_FAULT     4
`define SDCT_BIT_PROTECT   3
`define SDCT_BIT_ROWREAD   2
`define SDCT_BIT_STOREWR   1
`define SDCT_BIT_RESTORE   0
`define SDCT_UNLOCK_KEY    4'h5
`define SDCT_RESET_KEY     4'hA

// Channel trigger fields, channels 0, 1, 2
`define SDCT_CH0_LO        6
`define SDCT_CH0_HI        5
`define SDCT_CH0_RUN       4
`define SDCT_CH1_LO        2
`define SDCT_CH1_HI        1
`define SDCT_CH1_RUN       0
`define SDCT_CH2_LO        14
`define SDCT_CH2_HI        13
`define SDCT_CH2_RUN       12
`define SDCT_BIT_CMPCLR    3

// Status fields
`define SDCT_ST_FCRC       15
`define SDCT_ST_UCRC       14
`define SDCT_ST_FIXED1     13
`define SDCT_ST_BUSY1      12
`define SDCT_ST_BUSY0      11
`define SDCT_ST_BUSY2      9
`define SDCT_ST_SBUSY      8

// Reset values
`define SDCT_RESET_VALUE   16'h0000
`define SDCT_PART_ID       6'h2A
`define SDCT_REV_ID        2'h0

// Soft reset pulse length in cycles
`define SDCT_SRST_CYCLES   4'h8

`endif

//--- sdct_pulse.v
// One-cycle command strobe with a busy refusal gate
`timescale 1ns/1ps
module sdct_pulse
(
	input  wire clock,
	input  wire nrst,
	input  wire fire,
	input  wire busy,
	output reg  strobe
);

	// Strobe is registered; a busy target drops the command
	always @(posedge clock or negedge nrst)
	begin
		if (!nrst)
			strobe <= 1'b0;
		else
			strobe <= fire & ~busy;
	end

endmodule

//--- sdct_level.v
// Sticky status flag, set wins over clear
`timescale 1ns/1ps
module sdct_level
(
	input  wire clock,
	input  wire nrst,
	input  wire set,
	input  wire clear,
	output reg  flag
);

	// Setting has priority so a coincident event is never lost
	always @(posedge clock or negedge nrst)
	begin
		if (!nrst)
			flag <= 1'b0;
		else if (set)
			flag <= 1'b1;
		else if (clear)
			flag <= 1'b0;
	end

endmodule

//--- sdct_regs.v
// Global trigger, channel trigger and device status register group
`timescale 1ns/1ps
`include "sdct_defines.vh"
module sdct_regs
(
	input  wire        clock,
	input  wire        nrst,
	input  wire [7:0]  reg_addr,
	input  wire        reg_wr,
	input  wire        reg_rd,
	input  wire [15:0] reg_wdata,
	output reg  [15:0] reg_rdata,
	input  wire        register_lock,
	input  wire [2:0]  sync_load_enable,
	input  wire [2:0]  clear_level_select,
	input  wire [2:0]  channel_busy,
	input  wire        store_busy_flag,
	input  wire        factory_crc_fail,
	input  wire        user_load_fail,
	output reg         unlock_key_valid,
	output reg         soft_reset,
	output reg  [2:0]  sync_output_load,
	output reg  [2:0]  clear_zero,
	output reg  [2:0]  clear_mid,
	output wire        fault_record_start,
	output wire        protect_start,
	output wire        store_row_read_trigger,
	output wire        store_write_trigger,
	output wire        store_restore_trigger,
	output wire [2:0]  margin_low_trigger,
	output wire [2:0]  margin_high_trigger,
	output reg  [2:0]  waveform_run,
	output reg         comparator_latch_clear
);

	// Stored state and decode wires
	reg  [3:0]  key;            // Readable unlock key field
	reg  [3:0]  srst_cnt;       // Soft reset stretch counter
	reg         factory_crc;    // Factory store CRC error
	wire        user_crc;       // User store CRC error
	wire        wr_glb;         // Write to global trigger
	wire        wr_chn;         // Write to channel trigger
	wire        wr_ok;          // Write accepted past lock
	wire        store_cmd;      // Unlocked write to global trigger
	wire [2:0]  lo_req;         // Margin-low requests per channel
	wire [2:0]  hi_req;         // Margin-high requests per channel
	wire [15:0] status;         // Assembled status word

	// Lock guards every field except the key, which must pass to unlock
	assign wr_ok  = reg_wr & ~register_lock;
	assign wr_glb = reg_wr & (reg_addr == `SDCT_ADDR_GLOBAL);
	assign wr_chn = wr_ok & (reg_addr == `SDCT_ADDR_CHANNEL);
	assign store_cmd = wr_glb & ~register_lock;

	// Per channel margin requests gathered from scattered bits
	assign lo_req = {reg_wdata[`SDCT_CH2_LO], reg_wdata[`SDCT_CH1_LO],
		reg_wdata[`SDCT_CH0_LO]} & {3{wr_chn}};
	assign hi_req = {reg_wdata[`SDCT_CH2_HI], reg_wdata[`SDCT_CH1_HI],
		reg_wdata[`SDCT_CH0_HI]} & {3{wr_chn}};

	// Key field and unlock detection
	always @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			key              <= 4'h0;
			unlock_key_valid <= 1'b0;
		end
		else if (soft_reset)
		begin
			key              <= 4'h0;
			unlock_key_valid <= 1'b0;
		end
		else if (wr_glb)
		begin
			key              <= reg_wdata[`SDCT_KEY_HI:`SDCT_KEY_LO];
			unlock_key_valid <= (reg_wdata[`SDCT_KEY_HI:`SDCT_KEY_LO] ==
				`SDCT_UNLOCK_KEY);
		end
	end

	// Soft reset stretched over a few cycles so the core sees it settle
	always @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			srst_cnt   <= 4'h0;
			soft_reset <= 1'b0;
		end
		else if (wr_glb && !register_lock &&
			reg_wdata[`SDCT_RST_HI:`SDCT_RST_LO] == `SDCT_RESET_KEY)
		begin
			srst_cnt   <= `SDCT_SRST_CYCLES;
			soft_reset <= 1'b1;
		end
		else if (srst_cnt != 4'h0)
		begin
			srst_cnt   <= srst_cnt - 4'h1;
			soft_reset <= (srst_cnt != 4'h1);
		end
		else
			soft_reset <= 1'b0;
	end

	// Global one-shot commands; trigger bits are never stored
	always @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			sync_output_load <= 3'h0;
			clear_zero       <= 3'h0;
			clear_mid        <= 3'h0;
		end
		else
		begin
			sync_output_load <= {3{wr_glb & ~register_lock &
				reg_wdata[`SDCT_BIT_LOAD]}} & sync_load_enable;
			clear_zero <= {3{wr_glb & ~register_lock &
				reg_wdata[`SDCT_BIT_CLEAR]}} & ~clear_level_select;
			clear_mid  <= {3{wr_glb & ~register_lock &
				reg_wdata[`SDCT_BIT_CLEAR]}} & clear_level_select;
		end
	end

	// Fault record and protect strobes
	sdct_pulse u_fault
	(
		.clock  (clock),
		.nrst   (nrst),
		.fire   (store_cmd & reg_wdata[`SDCT_BIT_FAULT]),
		.busy   (store_busy_flag),
		.strobe (fault_record_start)
	);
	sdct_pulse u_protect
	(
		.clock  (clock),
		.nrst   (nrst),
		.fire   (store_cmd & reg_wdata[`SDCT_BIT_PROTECT]),
		.busy   (1'b0),
		.strobe (protect_start)
	);

	// Store commands dropped while the store is busy
	sdct_pulse u_rowrd
	(
		.clock  (clock),
		.nrst   (nrst),
		.fire   (store_cmd & reg_wdata[`SDCT_BIT_ROWREAD]),
		.busy   (store_busy_flag),
		.strobe (store_row_read_trigger)
	);
	sdct_pulse u_storewr
	(
		.clock  (clock),
		.nrst   (nrst),
		.fire   (store_cmd & reg_wdata[`SDCT_BIT_STOREWR]),
		.busy   (store_busy_flag),
		.strobe (store_write_trigger)
	);
	sdct_pulse u_restore
	(
		.clock  (clock),
		.nrst   (nrst),
		.fire   (store_cmd & reg_wdata[`SDCT_BIT_RESTORE]),
		.busy   (store_busy_flag),
		.strobe (store_restore_trigger)
	);

	// Per channel margin strobes, refused while the channel is busy
	genvar ch;
	generate
		for (ch = 0; ch < 3; ch = ch + 1)
		begin : g_ch
			sdct_pulse u_lo
			(
				.clock  (clock),
				.nrst   (nrst),
				.fire   (lo_req[ch]),
				.busy   (channel_busy[ch]),
				.strobe (margin_low_trigger[ch])
			);
			sdct_pulse u_hi
			(
				.clock  (clock),
				.nrst   (nrst),
				.fire   (hi_req[ch]),
				.busy   (channel_busy[ch]),
				.strobe (margin_high_trigger[ch])
			);
		end
	endgenerate

	// Waveform run levels and comparator latch clear
	always @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			waveform_run           <= 3'h0;
			comparator_latch_clear <= 1'b0;
		end
		else if (soft_reset)
		begin
			waveform_run           <= 3'h0;
			comparator_latch_clear <= 1'b0;
		end
		else
		begin
			comparator_latch_clear <= wr_chn & reg_wdata[`SDCT_BIT_CMPCLR];
			if (wr_chn)
				waveform_run <= {reg_wdata[`SDCT_CH2_RUN], reg_wdata[`SDCT_CH1_RUN],
					reg_wdata[`SDCT_CH0_RUN]};
		end
	end

	// Factory CRC error is sticky once its source pulses; a soft reset drops it
	always @(posedge clock or negedge nrst)
	begin
		if (!nrst)
			factory_crc <= 1'b0;
		else if (factory_crc_fail)
			factory_crc <= 1'b1;
		else if (soft_reset)
			factory_crc <= 1'b0;
	end

	// User CRC error is sticky; operations continue while it is set
	sdct_level u_ucrc
	(
		.clock (clock),
		.nrst  (nrst),
		.set   (user_load_fail),
		.clear (soft_reset),
		.flag  (user_crc)
	);

	// Status word assembly
	assign status = {factory_crc, user_crc, 1'b1, channel_busy[1], channel_busy[0],
		1'b0, channel_busy[2], store_busy_flag, `SDCT_PART_ID, `SDCT_REV_ID};

	// Read mux; trigger bits and unused bits read as zero
	always @(posedge clock or negedge nrst)
	begin
		if (!nrst)
			reg_rdata <= `SDCT_RESET_VALUE;
		else if (reg_rd)
		begin
			case (reg_addr)
				`SDCT_ADDR_GLOBAL:
					reg_rdata <= {key, 12'h000};
				`SDCT_ADDR_CHANNEL:
					reg_rdata <= {3'h0, waveform_run[2], 7'h00, waveform_run[0],
						3'h0, waveform_run[1]};
				`SDCT_ADDR_STATUS:
					reg_rdata <= status;
				default:
					reg_rdata <= 16'h0000;
			endcase
		end
	end

endmodule

//--- sdct_properties.sv
// Checker for the command and status register group
`timescale 1ns/1ps
`include "sdct_defines.vh"
module sdct_chk
(
	input wire        clock,
	input wire        nrst,
	input wire [7:0]  reg_addr,
	input wire        reg_wr,
	input wire        reg_rd,
	input wire [15:0] reg_wdata,
	input wire [15:0] reg_rdata,
	input wire        register_lock,
	input wire [2:0]  sync_load_enable,
	input wire [2:0]  channel_busy,
	input wire        store_busy_flag,
	input wire        unlock_key_valid,
	input wire        soft_reset,
	input wire [2:0]  sync_output_load,
	input wire        protect_start,
	input wire        store_write_trigger,
	input wire        store_restore_trigger,
	input wire [2:0]  margin_low_trigger,
	input wire [2:0]  margin_high_trigger,
	input wire [2:0]  waveform_run
);
	default clocking @(posedge clock); endclocking
	default disable iff (!nrst);
	// Accepted writes; a running soft reset may swallow writes
	wire gw = reg_wr && reg_addr == 8'h20 && !register_lock && !soft_reset;
	wire cw = reg_wr && reg_addr == 8'h21 && !register_lock && !soft_reset;
	property p_swr; gw && reg_wdata[1] && !store_busy_flag |=> store_write_trigger; endproperty
	a_swr: assert property (p_swr) else $error("store write lost");
	property p_prot; gw && reg_wdata[3] |=> protect_start; endproperty
	a_prot: assert property (p_prot) else $error("protect lost");
	property p_rest;
		store_restore_trigger |->
			$past(reg_wr && reg_addr == 8'h20 && !register_lock && reg_wdata[0]);
	endproperty
	a_rest: assert property (p_rest) else $error("restore uncaused");
	property p_srst; gw && reg_wdata[11:8] == 4'hA |=> soft_reset[*8]; endproperty
	a_srst: assert property (p_srst) else $error("soft reset short");
	property p_key;
		reg_wr && reg_addr == 8'h20 && !soft_reset |=>
			unlock_key_valid == ($past(reg_wdata[15:12]) == 4'h5);
	endproperty
	a_key: assert property (p_key) else $error("key wrong");
	property p_load; gw && reg_wdata[7] |=> sync_output_load == $past(sync_load_enable); endproperty
	a_load: assert property (p_load) else $error("load wrong");
	property p_mlo; cw && reg_wdata[14] && !channel_busy[2] |=> margin_low_trigger[2]; endproperty
	a_mlo: assert property (p_mlo) else $error("margin low lost");
	property p_busy; cw && reg_wdata[1] && channel_busy[1] |=> !margin_high_trigger[1]; endproperty
	a_busy: assert property (p_busy) else $error("busy ignored");
	property p_run;
		cw |=> waveform_run == $past({reg_wdata[12], reg_wdata[0], reg_wdata[4]});
	endproperty
	a_run: assert property (p_run) else $error("run wrong");
	property p_stat;
		reg_rd && reg_addr == 8'h22 |=> reg_rdata[13:0] == {1'b1, $past(channel_busy[1]),
			$past(channel_busy[0]), 1'b0, $past(channel_busy[2]), $past(store_busy_flag),
			`SDCT_PART_ID, `SDCT_REV_ID};
	endproperty
	a_stat: assert property (p_stat) else $error("status wrong");
endmodule

//--- sdct_cfg_model.sv
// Model of the configuration owner that holds the lock bit
`timescale 1ns/1ps
module sdct_cfg_model
(
	input  wire clock,
	input  wire nrst,
	input  wire lock_req,
	input  wire unlock_req,
	input  wire unlock_key_valid,
	output reg  register_lock
);
	// Clearing only works after a good key, so a stray write cannot unlock
	always @(posedge clock or negedge nrst)
	begin
		if (!nrst)
			register_lock <= 1'b0;
		else if (lock_req)
			register_lock <= 1'b1;
		else if (unlock_req && unlock_key_valid)
			register_lock <= 1'b0;
	end
endmodule

//--- test_dac_command_trigger_regs.sv
// Self-checking bench for the command and status register group
`timescale 1ns/1ps
`include "sdct_defines.vh"
`define CHK(a,b) begin samples_checked++; if ((a) !== (b)) begin mismatches++; \
	$display("[ERR] %0t %h %h", $time, a, b); end end
module test_dac_command_trigger_regs;
	reg         clock = 1'b0;
	reg         nrst = 1'b0;
	reg  [7:0]  reg_addr = 8'h00;
	reg         reg_wr = 1'b0;
	reg         reg_rd = 1'b0;
	reg  [15:0] reg_wdata = 16'h0000;
	reg  [2:0]  sync_load_enable = 3'h0;
	reg  [2:0]  clear_level_select = 3'h0;
	reg  [2:0]  channel_busy = 3'h0;
	reg         store_busy_flag = 1'b0;
	reg         factory_crc_fail = 1'b0;
	reg         user_load_fail = 1'b0;
	reg         lock_req = 1'b0;
	reg         unlock_req = 1'b0;
	wire [15:0] reg_rdata;
	wire        register_lock, unlock_key_valid, soft_reset, fault_record_start;
	wire        protect_start, store_row_read_trigger, store_write_trigger;
	wire        store_restore_trigger, comparator_latch_clear;
	wire [2:0]  sync_output_load, clear_zero, clear_mid, margin_low_trigger;
	wire [2:0]  margin_high_trigger, waveform_run;
	integer     mismatches = 0;
	integer     samples_checked = 0;
	integer     cycles = 0;
	integer     i;
	// Global strobes, index equals the trigger bit
	wire [4:0]  gp = {fault_record_start, protect_start, store_row_read_trigger,
		store_write_trigger, store_restore_trigger};
	sdct_regs u_sdct_regs (.clock(clock), .nrst(nrst), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.register_lock(register_lock), .sync_load_enable(sync_load_enable),
		.clear_level_select(clear_level_select), .channel_busy(channel_busy),
		.store_busy_flag(store_busy_flag), .factory_crc_fail(factory_crc_fail),
		.user_load_fail(user_load_fail), .unlock_key_valid(unlock_key_valid),
		.soft_reset(soft_reset), .sync_output_load(sync_output_load),
		.clear_zero(clear_zero), .clear_mid(clear_mid),
		.fault_record_start(fault_record_start), .protect_start(protect_start),
		.store_row_read_trigger(store_row_read_trigger),
		.store_write_trigger(store_write_trigger),
		.store_restore_trigger(store_restore_trigger),
		.margin_low_trigger(margin_low_trigger), .margin_high_trigger(margin_high_trigger),
		.waveform_run(waveform_run), .comparator_latch_clear(comparator_latch_clear));
	sdct_cfg_model u_sdct_cfg_model (.clock(clock), .nrst(nrst), .lock_req(lock_req),
		.unlock_req(unlock_req), .unlock_key_valid(unlock_key_valid),
		.register_lock(register_lock));
	always #5 clock = ~clock;
	task stop_test;
		$display("mismatches=%0d samples_checked=%0d", mismatches, samples_checked);
		if (mismatches == 0 && samples_checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// Hang guard, far above the length of the sequence
	always @(posedge clock)
	begin
		cycles++;
		if (cycles == 2000)
		begin
			mismatches++;
			stop_test;
		end
	end
	// One write, outputs settled in the answer cycle on return
	task wr(input [7:0] a, input [15:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clock);
		reg_wr <= 1'b0;
		#1;
	endtask
	task rd(input [7:0] a, input [15:0] e);
		@(posedge clock);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clock);
		reg_rd <= 1'b0;
		#1;
		`CHK(reg_rdata, e)
	endtask
	initial
	begin
		repeat (12) @(posedge clock);
		nrst <= 1'b1;
		rd(8'h20, 16'h0000);
		rd(8'h21, 16'h0000);
		rd(8'h22, 16'h20A8);
		rd(8'h30, 16'h0000);
		for (i = 0; i < 5; i++)
		begin
			wr(8'h20, 16'h0001 << i);
			`CHK(gp, 5'h01 << i)
		end
		rd(8'h20, 16'h0000);
		@(posedge clock);
		sync_load_enable <= 3'h5;
		clear_level_select <= 3'h6;
		wr(8'h20, 16'h0080);
		`CHK(sync_output_load, 3'h5)
		wr(8'h20, 16'h0040);
		`CHK({clear_mid, clear_zero}, 6'h31)
		wr(8'h21, 16'h707F);
		`CHK({margin_low_trigger, margin_high_trigger, comparator_latch_clear}, 7'h7F)
		rd(8'h21, 16'h1011);
		@(posedge clock);
		channel_busy <= 3'h2;
		wr(8'h21, 16'h6066);
		`CHK({margin_low_trigger, margin_high_trigger, waveform_run}, 9'h168)
		@(posedge clock);
		store_busy_flag <= 1'b1;
		wr(8'h20, 16'h001F);
		`CHK(gp, 5'h08)
		rd(8'h22, 16'h31A8);
		@(posedge clock);
		user_load_fail <= 1'b1;
		factory_crc_fail <= 1'b1;
		@(posedge clock);
		user_load_fail <= 1'b0;
		factory_crc_fail <= 1'b0;
		rd(8'h22, 16'hF1A8);
		@(posedge clock);
		channel_busy <= 3'h0;
		store_busy_flag <= 1'b0;
		wr(8'h20, 16'h0A00);
		`CHK(soft_reset, 1'b1)
		repeat (10) @(posedge clock);
		rd(8'h22, 16'h20A8);
		@(posedge clock);
		lock_req <= 1'b1;
		@(posedge clock);
		lock_req <= 1'b0;
		wr(8'h20, 16'h0002);
		`CHK(store_write_trigger, 1'b0)
		wr(8'h20, 16'h6000);
		`CHK(unlock_key_valid, 1'b0)
		wr(8'h20, 16'h5000);
		`CHK(unlock_key_valid, 1'b1)
		@(posedge clock);
		unlock_req <= 1'b1;
		@(posedge clock);
		unlock_req <= 1'b0;
		wr(8'h20, 16'h0002);
		`CHK(store_write_trigger, 1'b1)
		stop_test;
	end
endmodule
bind sdct_regs sdct_chk u_sdct_chk (.clock(clock), .nrst(nrst), .reg_addr(reg_addr),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
	.register_lock(register_lock), .sync_load_enable(sync_load_enable),
	.channel_busy(channel_busy), .store_busy_flag(store_busy_flag),
	.unlock_key_valid(unlock_key_valid), .soft_reset(soft_reset),
	.sync_output_load(sync_output_load), .protect_start(protect_start),
	.store_write_trigger(store_write_trigger), .store_restore_trigger(store_restore_trigger),
	.margin_low_trigger(margin_low_trigger), .margin_high_trigger(margin_high_trigger),
	.waveform_run(waveform_run));
